// file: rtl/pmrc_pkg.sv
package pmrc_pkg;

   // register byte addresses on the AHB-Lite slave
   localparam logic [11:0] ADDR_CAUSE = 12'hFF0;
   localparam logic [11:0] ADDR_RELOAD_UPPER = 12'hF00;
   localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hF04;
   localparam logic [11:0] ADDR_RELOAD_LOW = 12'hF08;
   localparam logic [11:0] ADDR_LOCK = 12'hF0C;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'hF10;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'hF14;
   localparam logic [11:0] ADDR_CTRL = 12'hF18;
   localparam logic [11:0] ADDR_MODE = 12'hF1C;

   // reset-cause field positions
   localparam int CAUSE_POR_BIT = 7;
   localparam int CAUSE_SLEEP_BIT = 6;
   localparam int CAUSE_WDOG_BIT = 5;
   localparam int CAUSE_PIN_BIT = 4;
   localparam logic [7:0] CAUSE_KEEP_MASK = 8'h0F;
   localparam logic [7:0] CAUSE_RST = 8'h00;

   // unlock byte sequence
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

   // watchdog reload reset value, one byte per register
   localparam logic [7:0] RELOAD_UPPER_RST = 8'h00;
   localparam logic [7:0] RELOAD_HIGH_RST = 8'h04;
   localparam logic [7:0] RELOAD_LOW_RST = 8'h00;

   // control and lock register bits
   localparam int CTRL_WDOG_EN_BIT = 0;
   localparam int LOCK_OPEN_BIT = 0;

   // interrupt status / mask layout
   localparam int IRQ_W = 4;
   localparam int IRQ_RECOVER = 0;
   localparam int IRQ_WDOG = 1;
   localparam int IRQ_PIN_RST = 2;
   localparam int IRQ_LOCK_VIOL = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [2:0] {
      PMRC_RUN = 3'b001,
      PMRC_IDLE = 3'b010,
      PMRC_SLEEP = 3'b100
   } pmrc_mode_t;

   typedef enum logic [1:0] {
      PMRC_UNL_WAIT = 2'b01,
      PMRC_UNL_HALF = 2'b10
   } pmrc_unlock_t;

   // asynchronous event inputs, in synchroniser order
   typedef struct packed {
      logic por;
      logic pin_rst;
      logic wdog_to;
      logic pin_wake;
   } pmrc_evt_t;

   typedef struct packed {
      pmrc_mode_t mode;
      pmrc_unlock_t unl;
      logic unlocked;
      logic [7:0] cause;
      logic [7:0] rl_upper;
      logic [7:0] rl_high;
      logic [7:0] rl_low;
      logic wdog_en;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic dp_valid;
      logic dp_write;
      logic rd_wait;
      logic [11:0] dp_addr;
      logic [31:0] hrdata;
      pmrc_evt_t evt_prev;
   } pmrc_state_t;

endpackage : pmrc_pkg

// file: rtl/pmrc_sync.sv
`timescale 1ns/100ps
module pmrc_sync #(
   parameter int WIDTH = 4,
   parameter int STAGES = 2
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [STAGES-1:0][WIDTH-1:0] chain;
   } pmrc_sync_state_t;

   pmrc_sync_state_t state_reg;
   pmrc_sync_state_t state_next;

   if (STAGES < 2) begin : g_check
      $error("pmrc_sync needs at least two stages");
   end

   // stage 0 feeds only stage 1
   always_comb begin
      state_next = state_reg;
      state_next.chain[0] = i_async;
      for (int k = 1; k < STAGES; k++) begin
         state_next.chain[k] = state_reg.chain[k-1];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= '0;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   assign o_sync = state_reg.chain[STAGES-1];

endmodule : pmrc_sync

// file: rtl/pmrc_top.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
// Summary of operation
// - the deep-sleep instruction stops the oscillator and system clock, halts the cpu, freezes pc.
// - in deep sleep the watchdog rc oscillator runs and the watchdog runs if enabled.
// - in deep sleep every other peripheral is held idle.
// - deep sleep ends only on a sleep-recovery event, returning to normal clocked operation.
// - the idle instruction halts the cpu and pc while oscillator and system clock keep running.
// - the reset-cause register is read-only and a read clears its upper four flags.
// - writing 55h then aah to the reset-cause address unlocks the three reload byte registers.
// - writes to the reset-cause address never change any bit of that register.
// - a power-on reset sets the power-on flag in bit 7.
// - a watchdog time-out or sleep recovery clears the power-on flag, as does a read.
// - a sleep recovery sets bit 6, and bit 5 too only when the watchdog caused it.
// - a power-on reset, or a time-out outside deep sleep, clears the sleep-recovery flag.
// - a time-out sets bit 5; power-on or a pin-change recovery clears it.
// - the reset pin sets bit 4; power-on or a pin-change recovery clears it.
module pmrc_top
   import pmrc_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_CLK_EN,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic O_HREADYOUT,
   output logic [31:0] O_HRDATA,
   output logic O_HRESP,
   input wire logic I_SLEEP_INSTR,
   input wire logic I_IDLE_INSTR,
   input wire logic I_IRQ_WAKE,
   input wire logic I_POR_EVENT,
   input wire logic I_PIN_RESET_EVENT,
   input wire logic I_WDOG_TIMEOUT,
   input wire logic I_PIN_CHANGE_WAKE,
   output logic O_OSC_EN,
   output logic O_SYSCLK_EN,
   output logic O_CPU_HALT,
   output logic O_PC_FREEZE,
   output logic O_PERIPH_IDLE,
   output logic O_WDOG_OSC_EN,
   output logic O_WDOG_RUN,
   output logic [23:0] O_WDOG_RELOAD,
   output logic [7:0] O_RESET_CAUSE,
   output logic O_RELOAD_UNLOCKED,
   output logic O_IRQ
);

   if (SYNC_STAGES < 2) begin : g_check
      $error("pmrc_top needs at least two synchroniser stages");
   end

   pmrc_state_t state_reg;
   pmrc_state_t state_next;
   pmrc_evt_t evt_sync;
   pmrc_evt_t evt;
   logic wr_done;
   logic rd_cap;
   logic sleeping;
   logic wake_wdog;
   logic wake_pin;
   logic wake_any;

   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
      addr_is = (a == off);
   endfunction : addr_is

   function automatic logic [31:0] read_word(input pmrc_state_t st, input logic [11:0] a);
      read_word = 32'h00000000;
      case (a)
         ADDR_CAUSE: read_word = {24'h000000, st.cause};
         ADDR_RELOAD_UPPER: read_word = {24'h000000, st.rl_upper};
         ADDR_RELOAD_HIGH: read_word = {24'h000000, st.rl_high};
         ADDR_RELOAD_LOW: read_word = {24'h000000, st.rl_low};
         ADDR_LOCK: read_word = {31'h00000000, st.unlocked};
         ADDR_IRQ_STAT: read_word = {28'h0000000, st.irq_stat};
         ADDR_IRQ_MASK: read_word = {28'h0000000, st.irq_mask};
         ADDR_CTRL: read_word = {31'h00000000, st.wdog_en};
         ADDR_MODE: read_word = {29'h00000000, st.mode};
         default: read_word = 32'h00000000;
      endcase
   endfunction : read_word

   // event pins come from other domains (power monitor, watchdog rc clock, pads)
   pmrc_sync #(
      .WIDTH(4),
      .STAGES(SYNC_STAGES)
   ) u_evt_sync (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_ce(I_CLK_EN),
      .i_async({I_POR_EVENT, I_PIN_RESET_EVENT, I_WDOG_TIMEOUT, I_PIN_CHANGE_WAKE}),
      .o_sync(evt_sync)
   );

   // rising edges only, so a level held high counts once
   assign evt.por = evt_sync.por & ~state_reg.evt_prev.por;
   assign evt.pin_rst = evt_sync.pin_rst & ~state_reg.evt_prev.pin_rst;
   // a disabled watchdog cannot time out
   assign evt.wdog_to = evt_sync.wdog_to & ~state_reg.evt_prev.wdog_to & state_reg.wdog_en;
   assign evt.pin_wake = evt_sync.pin_wake & ~state_reg.evt_prev.pin_wake;

   assign sleeping = (state_reg.mode == PMRC_SLEEP);
   assign wake_wdog = sleeping & evt.wdog_to;
   assign wake_pin = sleeping & evt.pin_wake;
   assign wake_any = wake_wdog | wake_pin;

   assign wr_done = state_reg.dp_valid & state_reg.dp_write;
   // reads take one wait state so read data come from a register
   assign rd_cap = state_reg.dp_valid & ~state_reg.dp_write & state_reg.rd_wait;

   always_comb begin
      state_next = state_reg;
      state_next.evt_prev = evt_sync;

      // ahb-lite address phase
      if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
         state_next.dp_valid = 1'b1;
         state_next.dp_write = I_HWRITE;
         state_next.dp_addr = I_HADDR[11:0];
         state_next.rd_wait = ~I_HWRITE;
      end else if (I_HREADY) begin
         state_next.dp_valid = 1'b0;
         state_next.rd_wait = 1'b0;
      end

      // read data phase: sample first, clear afterwards
      if (rd_cap) begin
         state_next.hrdata = read_word(state_reg, state_reg.dp_addr);
         state_next.rd_wait = 1'b0;
         if (addr_is(state_reg.dp_addr, ADDR_CAUSE)) begin
            state_next.cause = state_reg.cause & CAUSE_KEEP_MASK;
         end
         if (addr_is(state_reg.dp_addr, ADDR_IRQ_STAT)) begin
            state_next.irq_stat = '0;
         end
      end

      // write data phase; the cause register itself is never written
      if (wr_done) begin
         state_next.unl = PMRC_UNL_WAIT;
         if (addr_is(state_reg.dp_addr, ADDR_CAUSE)) begin
            if (state_reg.unl == PMRC_UNL_HALF && I_HWDATA[7:0] == UNLOCK_SECOND) begin
               state_next.unlocked = 1'b1;
            end else if (I_HWDATA[7:0] == UNLOCK_FIRST) begin
               state_next.unl = PMRC_UNL_HALF;
            end
         end
         case (state_reg.dp_addr)
            ADDR_RELOAD_UPPER: begin
               if (state_reg.unlocked) begin
                  state_next.rl_upper = I_HWDATA[7:0];
               end else begin
                  state_next.irq_stat[IRQ_LOCK_VIOL] = 1'b1;
               end
            end
            ADDR_RELOAD_HIGH: begin
               if (state_reg.unlocked) begin
                  state_next.rl_high = I_HWDATA[7:0];
               end else begin
                  state_next.irq_stat[IRQ_LOCK_VIOL] = 1'b1;
               end
            end
            ADDR_RELOAD_LOW: begin
               // the low byte completes a reload change and closes the lock again
               if (state_reg.unlocked) begin
                  state_next.rl_low = I_HWDATA[7:0];
                  state_next.unlocked = 1'b0;
               end else begin
                  state_next.irq_stat[IRQ_LOCK_VIOL] = 1'b1;
               end
            end
            ADDR_IRQ_MASK: state_next.irq_mask = I_HWDATA[IRQ_W-1:0];
            ADDR_CTRL: state_next.wdog_en = I_HWDATA[CTRL_WDOG_EN_BIT];
            default: state_next.irq_mask = state_next.irq_mask;
         endcase
      end

      // cause flags: hardware events after the read clear, so a set wins
      if (evt.pin_rst) begin
         state_next.cause[CAUSE_PIN_BIT] = 1'b1;
      end
      if (evt.wdog_to) begin
         state_next.cause[CAUSE_WDOG_BIT] = 1'b1;
         state_next.cause[CAUSE_POR_BIT] = 1'b0;
         state_next.cause[CAUSE_SLEEP_BIT] = sleeping;
      end
      if (wake_pin) begin
         state_next.cause[CAUSE_SLEEP_BIT] = 1'b1;
         state_next.cause[CAUSE_POR_BIT] = 1'b0;
         state_next.cause[CAUSE_WDOG_BIT] = 1'b0;
         state_next.cause[CAUSE_PIN_BIT] = 1'b0;
      end
      if (evt.por) begin
         state_next.cause[CAUSE_POR_BIT] = 1'b1;
         state_next.cause[CAUSE_SLEEP_BIT] = 1'b0;
         state_next.cause[CAUSE_WDOG_BIT] = 1'b0;
         state_next.cause[CAUSE_PIN_BIT] = 1'b0;
      end

      state_next.irq_stat[IRQ_RECOVER] = state_next.irq_stat[IRQ_RECOVER] | wake_any;
      state_next.irq_stat[IRQ_WDOG] = state_next.irq_stat[IRQ_WDOG] | evt.wdog_to;
      state_next.irq_stat[IRQ_PIN_RST] = state_next.irq_stat[IRQ_PIN_RST] | evt.pin_rst;

      // power mode machine
      case (state_reg.mode)
         PMRC_RUN: begin
            if (I_SLEEP_INSTR) begin
               state_next.mode = PMRC_SLEEP;
            end else if (I_IDLE_INSTR) begin
               state_next.mode = PMRC_IDLE;
            end
         end
         PMRC_IDLE: begin
            if (I_IRQ_WAKE || evt.wdog_to || evt.pin_wake) begin
               state_next.mode = PMRC_RUN;
            end
         end
         PMRC_SLEEP: begin
            // resets and interrupts do not wake; only a recovery event does
            if (wake_any) begin
               state_next.mode = PMRC_RUN;
            end
         end
         default: state_next.mode = PMRC_RUN;
      endcase
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         state_reg <= '0;
         state_reg.mode <= PMRC_RUN;
         state_reg.unl <= PMRC_UNL_WAIT;
         state_reg.cause <= CAUSE_RST;
         state_reg.rl_upper <= RELOAD_UPPER_RST;
         state_reg.rl_high <= RELOAD_HIGH_RST;
         state_reg.rl_low <= RELOAD_LOW_RST;
         state_reg.irq_mask <= IRQ_MASK_RST;
      end else if (I_CLK_EN) begin
         state_reg <= state_next;
      end
   end

   assign O_HREADYOUT = ~rd_cap;
   assign O_HRDATA = state_reg.hrdata;
   assign O_HRESP = HRESP_OKAY;

   assign O_OSC_EN = ~sleeping;
   assign O_SYSCLK_EN = ~sleeping;
   assign O_CPU_HALT = (state_reg.mode != PMRC_RUN);
   assign O_PC_FREEZE = (state_reg.mode != PMRC_RUN);
   assign O_PERIPH_IDLE = sleeping;
   // the watchdog keeps its own oscillator in every mode
   assign O_WDOG_OSC_EN = 1'b1;
   assign O_WDOG_RUN = state_reg.wdog_en;
   assign O_WDOG_RELOAD = {state_reg.rl_upper, state_reg.rl_high, state_reg.rl_low};
   assign O_RESET_CAUSE = state_reg.cause;
   assign O_RELOAD_UNLOCKED = state_reg.unlocked;
   assign O_IRQ = |(state_reg.irq_stat & state_reg.irq_mask);

   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_SYS_RST);

   a_sleep_entry: assert property (
      I_CLK_EN && state_reg.mode == PMRC_RUN && I_SLEEP_INSTR
      |=> state_reg.mode == PMRC_SLEEP && !O_OSC_EN && !O_SYSCLK_EN && O_CPU_HALT && O_PC_FREEZE)
      else $error("deep sleep entry did not stop clocks and cpu");

   a_wdog_sleep_run: assert property (
      I_CLK_EN && sleeping && evt.wdog_to
      |=> O_WDOG_OSC_EN && !sleeping && O_RESET_CAUSE[CAUSE_WDOG_BIT])
      else $error("watchdog not kept running in deep sleep");

   a_periph_idle: assert property (
      $rose(sleeping) |-> O_PERIPH_IDLE ##1 (O_PERIPH_IDLE == sleeping))
      else $error("peripherals not idle in deep sleep");

   a_sleep_exit_only: assert property (
      I_CLK_EN && sleeping && !wake_any |=> sleeping)
      else $error("deep sleep left without a recovery event");

   a_idle_clocks_on: assert property (
      state_reg.mode == PMRC_IDLE |-> O_OSC_EN && O_SYSCLK_EN && O_CPU_HALT && O_PC_FREEZE)
      else $error("idle mode clock or cpu state wrong");

   a_read_clears: assert property (
      I_CLK_EN && rd_cap && addr_is(state_reg.dp_addr, ADDR_CAUSE)
      && !(|evt) |=> state_reg.cause[7:4] == 4'h0)
      else $error("reset cause flags not cleared by read");

   a_read_old_value: assert property (
      I_CLK_EN && rd_cap && addr_is(state_reg.dp_addr, ADDR_CAUSE)
      |=> O_HRDATA[7:0] == $past(state_reg.cause) && O_HREADYOUT)
      else $error("reset cause read did not return the value before the clear");

   a_unlock_pair: assert property (
      I_CLK_EN && !state_reg.unlocked ##1 state_reg.unlocked
      |-> $past(state_reg.unl) == PMRC_UNL_HALF && $past(wr_done))
      else $error("reload unlocked without the byte pair");

   a_unlock_broken: assert property (
      I_CLK_EN && wr_done && !addr_is(state_reg.dp_addr, ADDR_CAUSE)
      && !state_reg.unlocked |=> !state_reg.unlocked && state_reg.unl == PMRC_UNL_WAIT)
      else $error("intervening write did not reset the unlock sequence");

   a_cause_write_none: assert property (
      I_CLK_EN && wr_done && addr_is(state_reg.dp_addr, ADDR_CAUSE)
      && !(|evt) && !rd_cap |=> $stable(state_reg.cause))
      else $error("write changed the reset cause register");

   a_por_sets: assert property (
      I_CLK_EN && evt.por |=> O_RESET_CAUSE[7:4] == 4'h8)
      else $error("power-on event did not give flags 1000");

   a_wdog_flags: assert property (
      I_CLK_EN && evt.wdog_to && !evt.por
      |=> !O_RESET_CAUSE[CAUSE_POR_BIT] && O_RESET_CAUSE[CAUSE_WDOG_BIT]
      && O_RESET_CAUSE[CAUSE_SLEEP_BIT] == $past(sleeping))
      else $error("watchdog time-out flags wrong");

   a_pin_wake_flags: assert property (
      I_CLK_EN && wake_pin && !evt.por && !evt.wdog_to && !evt.pin_rst
      |=> O_RESET_CAUSE[7:4] == 4'h4)
      else $error("pin-change recovery flags wrong");

   a_pin_rst_flag: assert property (
      I_CLK_EN && evt.pin_rst && !evt.por && !wake_pin |=> O_RESET_CAUSE[CAUSE_PIN_BIT])
      else $error("reset pin did not set its flag");

endmodule : pmrc_top

// file: tb/power_mode_reset_cause_bench.sv
`timescale 1ns/100ps
module power_mode_reset_cause_bench;
   import pmrc_pkg::*;
   localparam int LIMIT = 5000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic hresp;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic sleep_i = 1'b0;
   logic idle_i = 1'b0;
   logic wake_i = 1'b0;
   logic por_e = 1'b0;
   logic pinrst_e = 1'b0;
   logic wdto_e = 1'b0;
   logic pinwk_e = 1'b0;
   logic osc_en, sysclk_en, cpu_halt, pc_freeze, periph_idle, wdog_osc_en, wdog_run;
   logic [23:0] reload;
   logic [7:0] cause;
   logic unlocked, irq, hr_q;
   logic [31:0] rd_q;
   int num_errors = 0;
   int n_checks = 0;
   int cyc_cnt = 0;
   logic [31:0] rv;

   pmrc_top dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(clk_en), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
      .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata),
      .O_HRESP(hresp), .I_SLEEP_INSTR(sleep_i), .I_IDLE_INSTR(idle_i), .I_IRQ_WAKE(wake_i),
      .I_POR_EVENT(por_e), .I_PIN_RESET_EVENT(pinrst_e), .I_WDOG_TIMEOUT(wdto_e),
      .I_PIN_CHANGE_WAKE(pinwk_e), .O_OSC_EN(osc_en), .O_SYSCLK_EN(sysclk_en),
      .O_CPU_HALT(cpu_halt), .O_PC_FREEZE(pc_freeze), .O_PERIPH_IDLE(periph_idle),
      .O_WDOG_OSC_EN(wdog_osc_en), .O_WDOG_RUN(wdog_run), .O_WDOG_RELOAD(reload),
      .O_RESET_CAUSE(cause), .O_RELOAD_UNLOCKED(unlocked), .O_IRQ(irq));

   initial begin
      forever #2 clk = ~clk;
   end

   // ready and read data are sampled mid-cycle, where they have settled after the edge
   always @(negedge clk) begin
      hr_q <= hready;
      rd_q <= hrdata;
   end

   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIMIT) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hr_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      do @(posedge clk); while (hr_q !== 1'b1);
      rv = rd_q;
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
      @(negedge clk);
   endtask : bus

   // async event: held two cycles, then time for the two-flop sync and edge detect
   task automatic evt(input int k);
      @(posedge clk);
      case (k)
         0: por_e <= 1'b1;
         1: pinrst_e <= 1'b1;
         2: wdto_e <= 1'b1;
         default: pinwk_e <= 1'b1;
      endcase
      repeat (2) @(posedge clk);
      {por_e, pinrst_e, wdto_e, pinwk_e} <= 4'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : evt

   task automatic instr(input int k);
      @(posedge clk);
      case (k)
         0: sleep_i <= 1'b1;
         1: idle_i <= 1'b1;
         default: wake_i <= 1'b1;
      endcase
      @(posedge clk);
      {sleep_i, idle_i, wake_i} <= 3'h0;
      @(posedge clk);
      @(negedge clk);
   endtask : instr

   task automatic pwr(input logic [4:0] exp);
      chk({osc_en, sysclk_en, cpu_halt, pc_freeze, periph_idle}, {27'h0, exp});
   endtask : pwr

   task automatic t_reset;
      chk({24'h0, cause}, {24'h0, CAUSE_RST});
      chk({8'h0, reload}, 32'h0000_0400);
      chk({unlocked, irq, hready}, 32'h1);
      pwr(5'h18);
      bus(1'b0, 12'hE00, 32'h0);
      chk(rv, 32'h0);
   endtask : t_reset

   task automatic t_por;
      evt(0);
      chk({24'h0, cause}, 32'h80);
      bus(1'b1, ADDR_CAUSE, 32'hFF);
      chk({24'h0, cause}, 32'h80);
      bus(1'b0, ADDR_CAUSE, 32'h0);
      chk(rv[7:0], 32'h80);
      chk({24'h0, cause}, 32'h0);
   endtask : t_por

   task automatic t_lock;
      bus(1'b1, ADDR_IRQ_MASK, 32'h8);
      bus(1'b1, ADDR_RELOAD_UPPER, 32'h12);
      chk({8'h0, reload}, 32'h0000_0400);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rv, 32'h8);
      @(posedge clk);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, ADDR_CAUSE, 32'h55);
      bus(1'b1, ADDR_IRQ_MASK, 32'h7);
      bus(1'b1, ADDR_CAUSE, 32'hAA);
      chk({31'h0, unlocked}, 32'h0);
      bus(1'b1, ADDR_CAUSE, 32'h55);
      bus(1'b1, ADDR_CAUSE, 32'hAA);
      chk({31'h0, unlocked}, 32'h1);
      bus(1'b0, ADDR_LOCK, 32'h0);
      chk(rv, 32'h1);
      chk({24'h0, cause}, 32'h0);
      bus(1'b1, ADDR_RELOAD_UPPER, 32'h12);
      bus(1'b1, ADDR_RELOAD_HIGH, 32'h34);
      bus(1'b1, ADDR_RELOAD_LOW, 32'h56);
      chk({8'h0, reload}, 32'h0012_3456);
      chk({31'h0, unlocked}, 32'h0);
   endtask : t_lock

   task automatic t_run_events;
      evt(1);
      chk({24'h0, cause}, 32'h10);
      bus(1'b1, ADDR_CTRL, 32'h1);
      chk({30'h0, wdog_run, wdog_osc_en}, 32'h3);
      evt(2);
      chk({24'h0, cause}, 32'h30);
      bus(1'b0, ADDR_CAUSE, 32'h0);
      chk({24'h0, cause}, 32'h0);
   endtask : t_run_events

   task automatic t_sleep_wdog;
      evt(0);
      instr(0);
      pwr(5'h07);
      chk({30'h0, wdog_run, wdog_osc_en}, 32'h3);
      instr(2);
      pwr(5'h07);
      evt(2);
      pwr(5'h18);
      chk({24'h0, cause}, 32'h60);
      evt(2);
      chk({24'h0, cause}, 32'h20);
   endtask : t_sleep_wdog

   task automatic t_sleep_pin;
      evt(1);
      chk({24'h0, cause}, 32'h30);
      instr(0);
      evt(3);
      pwr(5'h18);
      chk({24'h0, cause}, 32'h40);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rv, 32'h7);
      evt(3);
      chk({24'h0, cause}, 32'h40);
   endtask : t_sleep_pin

   task automatic t_idle;
      instr(1);
      pwr(5'h1E);
      bus(1'b0, ADDR_MODE, 32'h0);
      chk(rv, 32'h2);
      instr(2);
      pwr(5'h18);
   endtask : t_idle

   // a sleep instruction while the enable is low must be lost; then reset mid-run
   task automatic t_freeze_reset;
      @(posedge clk);
      clk_en <= 1'b0;
      instr(0);
      pwr(5'h18);
      @(posedge clk);
      clk_en <= 1'b1;
      @(negedge clk);
      pwr(5'h18);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({24'h0, cause}, {24'h0, CAUSE_RST});
      chk({8'h0, reload}, 32'h0000_0400);
      chk({30'h0, unlocked, wdog_run}, 32'h0);
      pwr(5'h18);
      bus(1'b0, ADDR_MODE, 32'h0);
      chk(rv, 32'h1);
   endtask : t_freeze_reset

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_reset();
      t_por();
      t_lock();
      t_run_events();
      t_sleep_wdog();
      t_sleep_pin();
      t_idle();
      t_freeze_reset();
      report_and_stop();
   end
endmodule : power_mode_reset_cause_bench
